// ==== core/erase_ctl_regs.svh ====
// Offsets, field positions, command codes and timing counts of the erase
// controller. Assumes a 100 MHz pclk and word-aligned APB registers.
`ifndef ERASE_CTL_REGS_SVH
`define ERASE_CTL_REGS_SVH
// Register byte offsets
`define REG_CTRL 12'h000
`define REG_SADDR 12'h004
`define REG_STATUS 12'h008
`define REG_POLL 12'h00C
// Control fields: op code in bits 2:0, go strobe in bit 31
`define CTRL_OP_LSB 0
`define CTRL_GO_BIT 31
// Operation codes written to the control register
`define OP_CHIP 3'h1
`define OP_SECTOR 3'h2
`define OP_ADD 3'h3
`define OP_SUSPEND 3'h4
`define OP_RESUME 3'h5
`define OP_READ 3'h6
// Command data and unlock addresses
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_SETUP 8'h80
`define CMD_CHIP 8'h10
`define CMD_SECTOR 8'h30
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'h30
`define ADDR_UNLOCK1 21'h00_0555
`define ADDR_UNLOCK2 21'h00_02AA
// Status bits
`define ST_BUSY 0
`define ST_ERR 1
`define ST_READY 2
`define ST_TIMER 3
`define ST_DONE 4
// Timing: sector add window and suspend latency in ns
`define ADD_WINDOW_NS 50000
`define SUSPEND_MAX_NS 35000
`define CLK_PERIOD_NS 10
`define ADD_WINDOW_CYC (`ADD_WINDOW_NS / `CLK_PERIOD_NS)
`define SUSPEND_CYC (`SUSPEND_MAX_NS / `CLK_PERIOD_NS)
// Counter loads of the write strobe low and high phases; each phase lasts one pclk cycle more
`define WE_LOW_CYC 4'h5
`define WE_HIGH_CYC 4'h3
`endif

// ==== core/erase_ctl_pkg.sv ====
// Types shared by the erase controller and its write-cycle engine.
// Assumes nothing beyond a SystemVerilog compiler.
package erase_ctl_pkg;
  typedef enum logic [4:0] {
    SQ_IDLE = 5'b00001,
    SQ_SEND = 5'b00010,
    SQ_WAIT = 5'b00100,
    SQ_READ = 5'b01000,
    SQ_DONE = 5'b10000
  } seq_e;
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_LOW = 3'b010,
    WR_HIGH = 3'b100
  } wr_e;
endpackage : erase_ctl_pkg

// ==== core/bus_cycle_if.sv ====
// Request and answer of one flash bus cycle between the sequencer and
// the cycle engine. Assumes a single pclk domain.
interface bus_cycle_if;
  logic req;
  logic rd;
  logic [20:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic done;
  modport master (output req, rd, addr, wdata, input rdata, done);
  modport engine (input req, rd, addr, wdata, output rdata, done);
endinterface : bus_cycle_if

// ==== core/bus_cycle_engine.sv ====
// Drives one flash write or read cycle on the device pins.
// Assumes a two-flop synchronised data input from the top.
`include "erase_ctl_regs.svh"
module bus_cycle_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  bus_cycle_if.engine cyc,
  input wire logic [7:0] din_sync,
  output logic we_n_r,
  output logic oe_n_r,
  output logic cs_n_r,
  output logic dq_oe_r
);
  erase_ctl_pkg::wr_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic rd_r, rd_nxt;
  logic done_r, done_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic we_n_nxt, oe_n_nxt, cs_n_nxt, dq_oe_nxt;
  assign cyc.done = done_r;
  assign cyc.rdata = rdata_r;
  // Strobe low phase, then high phase; data latched at rising strobe
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rd_nxt = rd_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    we_n_nxt = we_n_r;
    oe_n_nxt = oe_n_r;
    cs_n_nxt = cs_n_r;
    dq_oe_nxt = dq_oe_r;
    case (st_r)
      erase_ctl_pkg::WR_IDLE: begin
        if (cyc.req) begin
          st_nxt = erase_ctl_pkg::WR_LOW;
          cnt_nxt = `WE_LOW_CYC;
          rd_nxt = cyc.rd;
          cs_n_nxt = 1'b0;
          we_n_nxt = cyc.rd;
          oe_n_nxt = !cyc.rd;
          dq_oe_nxt = !cyc.rd;
        end
      end
      erase_ctl_pkg::WR_LOW: begin
        if (cnt_r == 4'h0) begin
          st_nxt = erase_ctl_pkg::WR_HIGH;
          cnt_nxt = `WE_HIGH_CYC;
          we_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          cs_n_nxt = 1'b1;
          // Read data sampled before the output enable is dropped
          if (rd_r) begin
            rdata_nxt = din_sync;
          end
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      erase_ctl_pkg::WR_HIGH: begin
        // Hold data past the rising strobe, then release the bus
        dq_oe_nxt = 1'b0;
        if (cnt_r == 4'h0) begin
          st_nxt = erase_ctl_pkg::WR_IDLE;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: st_nxt = erase_ctl_pkg::WR_IDLE;
    endcase
  end
  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= erase_ctl_pkg::WR_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 8'h00;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      cs_n_r <= 1'b1;
      dq_oe_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      we_n_r <= we_n_nxt;
      oe_n_r <= oe_n_nxt;
      cs_n_r <= cs_n_nxt;
      dq_oe_r <= dq_oe_nxt;
    end
  end
  a_strobe_pair: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(we_n_r) |-> !cs_n_r && dq_oe_r)
    else $error("write strobe without select or data drive");
endmodule : bus_cycle_engine

// ==== core/window_timer.sv ====
// Down counter for the sector add window and the suspend latency.
// Assumes load and tick come from logic on pclk.
module window_timer #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic clear,
  output logic running,
  output logic expired
);
  logic [WIDTH-1:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt;
  logic exp_r, exp_nxt;
  assign running = run_r;
  assign expired = exp_r;
  // Load restarts, clear abandons, zero raises a one-cycle expiry
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    exp_nxt = 1'b0;
    if (clear) begin
      run_nxt = 1'b0;
    end else if (load) begin
      cnt_nxt = load_val;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r == '0) begin
        run_nxt = 1'b0;
        exp_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      exp_r <= exp_nxt;
    end
  end
endmodule : window_timer

// ==== core/flash_erase_host.sv ====
// Host controller that issues erase, suspend and resume command cycles
// to a parallel NOR flash and watches its ready/busy pin.
// Assumes an APB master on pclk and flash pins outside the clock domain.
// What the datasheet asks of the host and the device
// R01 - Chip erase is six writes: two unlocks, setup, two unlocks, command.
// R02 - Device preprograms by itself; the host sends nothing extra for it.
// R03 - Device ignores commands during chip erase; host sends none then.
// R04 - Hardware reset aborts chip erase; reissue the whole sequence after.
// R05 - Device shows progress on status bits and ready/busy until finished.
// R06 - Sector erase is six writes, last carrying sector address and command.
// R07 - A 50 us add window starts at the final rising write strobe.
// R08 - Further single sector writes queue more sectors inside the window.
// R09 - Host spaces added sector writes under 50 us apart.
// R10 - Other commands in the window abort; host must rewrite everything.
// R11 - Device offers a timer bit telling whether the window expired.
// R12 - Once erasing, only suspend is accepted by the device.
// R13 - Hardware reset aborts sector erase; reissue the sequence after.
// R14 - Suspend is valid only in sector erase, address ignored.
// R15 - Suspend takes effect within 35 us, or at once in the window.
// R16 - Suspended device allows reads and programs outside erased sectors.
// R17 - Reads in suspended sectors return status on the data byte.
// R18 - Program during suspend reports status bits as usual.
// R19 - Autoselect works during suspend and returns to suspend on exit.
// R20 - Resume continues erasing; repeats ignored; suspend allowed again.
// R21 - Each added sector write restarts the 50 us window.
// R22 - Chip erase uses data 80 on cycle three and 10 on cycle six.
// R23 - Sector writes carry data 30 at the sector address.
// R24 - Suspend is one write of B0 at any address.
// R25 - Resume is one write of 30 at any address.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`include "erase_ctl_regs.svh"
module flash_erase_host #(
  parameter int unsigned ADD_WINDOW = `ADD_WINDOW_CYC,
  parameter int unsigned SUSPEND_WAIT = `SUSPEND_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [20:0] flash_addr,
  input wire logic [7:0] data_bus_byte_in,
  output logic [7:0] data_bus_byte_out,
  output logic data_bus_byte_oe,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_cs_n,
  output logic flash_reset_n,
  input wire logic ready_busy_output
);
  localparam int unsigned TW = 16;
  bus_cycle_if cyc ();
  erase_ctl_pkg::seq_e st_r, st_nxt;
  // Pin synchronisers
  logic [7:0] din_m_r, din_s_r;
  logic rb_m_r, rb_s_r;
  // Sequencer state
  logic [2:0] idx_r, idx_nxt;
  logic [2:0] last_r, last_nxt;
  logic [2:0] op_r, op_nxt;
  logic [20:0] saddr_r, saddr_nxt;
  logic [7:0] poll_r, poll_nxt;
  logic busy_r, busy_nxt;
  logic err_r, err_nxt;
  logic done_r, done_nxt;
  logic in_window_r, in_window_nxt;
  logic susp_r, susp_nxt;
  logic req_r, req_nxt;
  logic rd_r, rd_nxt;
  logic [20:0] caddr_r, caddr_nxt;
  logic [7:0] cdata_r, cdata_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic rst_out_r;
  // Timer control
  logic t_load, t_clear, t_run, t_exp;
  logic [TW-1:0] t_val;
  logic [2:0] wr_op;
  logic go;
  assign cyc.req = req_r;
  assign cyc.rd = rd_r;
  assign cyc.addr = caddr_r;
  assign cyc.wdata = cdata_r;
  assign flash_addr = caddr_r;
  assign data_bus_byte_out = cdata_r;
  assign flash_reset_n = rst_out_r;

  // Address and data of cycle n of a six-cycle erase sequence
  function automatic logic [28:0] erase_cycle(input logic [2:0] n,
                                              input logic chip,
                                              input logic [20:0] sa);
    logic [28:0] r;
    r = {`ADDR_UNLOCK1, `CMD_UNLOCK1};
    case (n)
      3'h1: r = {`ADDR_UNLOCK2, `CMD_UNLOCK2};
      3'h2: r = {`ADDR_UNLOCK1, `CMD_SETUP};
      3'h3: r = {`ADDR_UNLOCK1, `CMD_UNLOCK1};
      3'h4: r = {`ADDR_UNLOCK2, `CMD_UNLOCK2};
      3'h5: r = chip ? {`ADDR_UNLOCK1, `CMD_CHIP} : {sa, `CMD_SECTOR};
      default: r = {`ADDR_UNLOCK1, `CMD_UNLOCK1};
    endcase
    return r;
  endfunction : erase_cycle

  // Two-flop synchronisers for data pins and ready/busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_m_r <= 8'h00;
      din_s_r <= 8'h00;
      rb_m_r <= 1'b1;
      rb_s_r <= 1'b1;
    end else if (clk_en) begin
      din_m_r <= data_bus_byte_in;
      din_s_r <= din_m_r;
      rb_m_r <= ready_busy_output;
      rb_s_r <= rb_m_r;
    end
  end

  // Timer: window restart on each sector write, or suspend latency
  // R21 window restart
  assign t_load = (st_r == erase_ctl_pkg::SQ_WAIT) && cyc.done &&
                  idx_r == last_r &&
                  (op_r == `OP_SECTOR || op_r == `OP_ADD ||
                   op_r == `OP_SUSPEND);
  assign t_val = (op_r == `OP_SUSPEND) ? TW'(SUSPEND_WAIT) :
                 TW'(ADD_WINDOW);
  // R10 a new erase sequence abandons any open add window
  assign t_clear = (st_r == erase_ctl_pkg::SQ_SEND) && idx_r == 3'h0 &&
                   (op_r == `OP_CHIP || op_r == `OP_SECTOR);

  window_timer #(.WIDTH(TW)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .load(t_load),
    .load_val(t_val),
    .clear(t_clear),
    .running(t_run),
    .expired(t_exp)
  );

  bus_cycle_engine u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .cyc(cyc.engine),
    .din_sync(din_s_r),
    .we_n_r(flash_we_n),
    .oe_n_r(flash_oe_n),
    .cs_n_r(flash_cs_n),
    .dq_oe_r(data_bus_byte_oe)
  );

  assign go = psel && penable && pwrite && !pready &&
              (paddr == `REG_CTRL) && pwdata[`CTRL_GO_BIT];
  assign wr_op = pwdata[`CTRL_OP_LSB +: 3];

  // Sequencer and APB slave; one-cycle wait state on every access
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    last_nxt = last_r;
    op_nxt = op_r;
    saddr_nxt = saddr_r;
    poll_nxt = poll_r;
    busy_nxt = busy_r;
    err_nxt = err_r;
    done_nxt = done_r;
    in_window_nxt = in_window_r;
    susp_nxt = susp_r;
    req_nxt = 1'b0;
    rd_nxt = rd_r;
    caddr_nxt = caddr_r;
    cdata_nxt = cdata_r;
    prdata_nxt = prdata;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    // R11 window expiry tracked locally; late adds risk a dropped sector
    if (t_exp) begin
      in_window_nxt = 1'b0;
    end
    if (psel && penable && !pready) begin
      pready_nxt = 1'b1;
      prdata_nxt = 32'h0000_0000;
      if (paddr == `REG_CTRL) begin
        prdata_nxt = {29'h0000_0000, op_r};
      end else if (paddr == `REG_SADDR) begin
        prdata_nxt = {11'h000, saddr_r};
        if (pwrite) begin
          saddr_nxt = pwdata[20:0];
        end
      end else if (paddr == `REG_STATUS) begin
        prdata_nxt = {27'h000_0000, done_r, in_window_r, rb_s_r, err_r,
                      busy_r};
        // Set wins: a finish in this same cycle keeps done
        if (pwrite && pwdata[`ST_DONE] && !(busy_r && cyc.done &&
            st_r == erase_ctl_pkg::SQ_WAIT)) begin
          done_nxt = 1'b0;
        end
        if (pwrite && pwdata[`ST_ERR]) begin
          err_nxt = 1'b0;
        end
      end else if (paddr == `REG_POLL) begin
        prdata_nxt = {24'h00_0000, poll_r};
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    case (st_r)
      erase_ctl_pkg::SQ_IDLE: begin
        if (go) begin
          op_nxt = wr_op;
          busy_nxt = 1'b1;
          idx_nxt = 3'h0;
          st_nxt = erase_ctl_pkg::SQ_SEND;
          // R01 six-cycle chip erase
          // R06 six-cycle sector erase
          last_nxt = 3'h5;
          if (wr_op == `OP_ADD || wr_op == `OP_SUSPEND ||
              wr_op == `OP_RESUME || wr_op == `OP_READ) begin
            last_nxt = 3'h0;
          end
          // R03 no command while chip erase runs
          // R12 only suspend once sector erasing
          // R08 adds still go out while the device counts its window
          // Refused orders keep the last accepted op for later checks
          if (!rb_s_r && wr_op != `OP_SUSPEND && wr_op != `OP_READ &&
              wr_op != `OP_ADD) begin
            op_nxt = op_r;
            err_nxt = 1'b1;
            busy_nxt = 1'b0;
            st_nxt = erase_ctl_pkg::SQ_IDLE;
          end
          // R14 suspend only for sector erase
          // R20 resume only while suspended
          // R09 adds only while the local window still runs
          if ((wr_op == `OP_SUSPEND && (susp_r || op_r == `OP_CHIP)) ||
              (wr_op == `OP_RESUME && !susp_r) ||
              (wr_op == `OP_ADD && !in_window_r) ||
              wr_op == 3'h0 || wr_op == 3'h7) begin
            op_nxt = op_r;
            err_nxt = 1'b1;
            busy_nxt = 1'b0;
            st_nxt = erase_ctl_pkg::SQ_IDLE;
          end
        end
      end
      erase_ctl_pkg::SQ_SEND: begin
        req_nxt = 1'b1;
        rd_nxt = 1'b0;
        st_nxt = erase_ctl_pkg::SQ_WAIT;
        if (op_r == `OP_CHIP || op_r == `OP_SECTOR) begin
          // R10 window ends once a new sequence goes out
          in_window_nxt = 1'b0;
          // R22 chip erase data
          // R23 sector command at sector address
          {caddr_nxt, cdata_nxt} = erase_cycle(idx_r, op_r == `OP_CHIP,
                                               saddr_r);
        end else if (op_r == `OP_ADD) begin
          // R08 single-cycle added sector
          {caddr_nxt, cdata_nxt} = {saddr_r, `CMD_SECTOR};
        end else if (op_r == `OP_SUSPEND) begin
          // R24 suspend code
          {caddr_nxt, cdata_nxt} = {saddr_r, `CMD_SUSPEND};
        end else if (op_r == `OP_RESUME) begin
          // R25 resume code
          {caddr_nxt, cdata_nxt} = {saddr_r, `CMD_RESUME};
        end else begin
          // R17 status or array read at the sector address
          rd_nxt = 1'b1;
          caddr_nxt = saddr_r;
        end
      end
      erase_ctl_pkg::SQ_WAIT: begin
        req_nxt = 1'b0;
        if (cyc.done) begin
          if (idx_r != last_r) begin
            idx_nxt = idx_r + 3'h1;
            st_nxt = erase_ctl_pkg::SQ_SEND;
          end else if (op_r == `OP_SUSPEND) begin
            // R15 allow the suspend latency before reporting done
            st_nxt = erase_ctl_pkg::SQ_DONE;
          end else begin
            st_nxt = erase_ctl_pkg::SQ_IDLE;
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            // R07 window opens once the engine reports the final write cycle done
            if (op_r == `OP_SECTOR || op_r == `OP_ADD) begin
              in_window_nxt = 1'b1;
            end
            if (op_r == `OP_RESUME) begin
              susp_nxt = 1'b0;
            end
            if (op_r == `OP_READ) begin
              poll_nxt = cyc.rdata;
            end
          end
        end
      end
      erase_ctl_pkg::SQ_DONE: begin
        in_window_nxt = 1'b0;
        if (t_exp || !t_run) begin
          st_nxt = erase_ctl_pkg::SQ_IDLE;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          susp_nxt = 1'b1;
        end
      end
      default: st_nxt = erase_ctl_pkg::SQ_IDLE;
    endcase
  end

  // Sequencer and bus registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= erase_ctl_pkg::SQ_IDLE;
      idx_r <= 3'h0;
      last_r <= 3'h0;
      op_r <= 3'h0;
      saddr_r <= 21'h00_0000;
      poll_r <= 8'h00;
      busy_r <= 1'b0;
      err_r <= 1'b0;
      done_r <= 1'b0;
      in_window_r <= 1'b0;
      susp_r <= 1'b0;
      req_r <= 1'b0;
      rd_r <= 1'b0;
      caddr_r <= 21'h00_0000;
      cdata_r <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rst_out_r <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      last_r <= last_nxt;
      op_r <= op_nxt;
      saddr_r <= saddr_nxt;
      poll_r <= poll_nxt;
      busy_r <= busy_nxt;
      err_r <= err_nxt;
      done_r <= done_nxt;
      in_window_r <= in_window_nxt;
      susp_r <= susp_nxt;
      req_r <= req_nxt;
      rd_r <= rd_nxt;
      caddr_r <= caddr_nxt;
      cdata_r <= cdata_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      // R04 R13 device reset follows controller reset
      rst_out_r <= 1'b1;
    end
  end

  // R22 chip erase third cycle carries setup
  a_setup_code: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && st_r == erase_ctl_pkg::SQ_SEND && idx_r == 3'h2 &&
     (op_r == `OP_CHIP || op_r == `OP_SECTOR)) |=> cdata_r == 8'h80)
    else $error("third erase cycle not setup code"); // R22
  a_chip_code: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && st_r == erase_ctl_pkg::SQ_SEND && idx_r == 3'h5 &&
     op_r == `OP_CHIP) |=> cdata_r == 8'h10)
    else $error("sixth chip cycle wrong"); // R01
  a_sector_code: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && st_r == erase_ctl_pkg::SQ_SEND &&
     (op_r == `OP_ADD || (op_r == `OP_SECTOR && idx_r == 3'h5)))
    |=> cdata_r == 8'h30 && caddr_r == saddr_r)
    else $error("sector cycle wrong"); // R23
  a_suspend_code: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && st_r == erase_ctl_pkg::SQ_SEND && op_r == `OP_SUSPEND)
    |=> cdata_r == 8'hB0)
    else $error("suspend code wrong"); // R24
  a_resume_code: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && st_r == erase_ctl_pkg::SQ_SEND && op_r == `OP_RESUME)
    |=> cdata_r == 8'h30)
    else $error("resume code wrong"); // R25
  a_window_open: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && t_load && op_r != `OP_SUSPEND) |=> in_window_r && t_run)
    else $error("add window not opened"); // R07
  a_resume_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && st_r == erase_ctl_pkg::SQ_WAIT && cyc.done &&
     op_r == `OP_RESUME) |=> !susp_r)
    else $error("resume left suspend set"); // R20
  a_busy_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && go && st_r == erase_ctl_pkg::SQ_IDLE && !rb_s_r &&
     wr_op == `OP_CHIP) |=> st_r == erase_ctl_pkg::SQ_IDLE && err_r)
    else $error("command sent while device busy"); // R03
endmodule : flash_erase_host

// ==== test/flash_model.sv ====
// Behavioural flash device on the far side of the erase controller pins.
// Assumes write strobes only pulse for write cycles; no clock of its own.
module flash_model #(
  parameter int WIN_NS = 2000,
  parameter int ERASE_NS = 3000
) (
  input wire logic rst_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic cs_n,
  input wire logic [20:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  output logic rb
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] SEQ [5] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55};
  int mode;
  int cyc;
  time t_end;
  logic [7:0] val;
  logic [20:0] sect;
  // busy while erasing or in the window
  assign rb = (mode == 0 || mode == 4);
  // suspended reads: status in the erase sector, array elsewhere
  assign val = (mode == 4 && addr == sect) ? 8'h80 : 8'hFF;
  // A released bus shows the inverse, so a late sample is caught
  assign dout = (!oe_n && !cs_n) ? val : ~val;
  always @(posedge we_n or negedge rst_n) begin
    if (!rst_n) begin
      mode = 0;
      cyc = 0;
    end else if (mode == 0 && cyc == 5) begin
      // erase then runs with no further host input
      cyc = 0;
      sect = addr;
      t_end = $time + ((din == 8'h10) ? ERASE_NS : WIN_NS);
      mode = (din == 8'h10) ? 1 : (din == 8'h30) ? 2 : 0;
    end else if (mode == 0) begin
      cyc = (din == SEQ[cyc]) ? cyc + 1 : 0;
    end else if (mode == 2 && din == 8'h30) begin
      t_end = $time + WIN_NS;
      sect = addr;
    end else if (mode == 2 || (mode == 3 && din == 8'hB0)) begin
      mode = (din == 8'hB0) ? 4 : 0;
    // other writes in suspend leave it standing
    end else if (mode == 4 && din == 8'h30) begin
      mode = 3;
      t_end = $time + ERASE_NS;
    end
  end
  // window runs out into erasing; erase ends in array reads
  always begin
    #50;
    if (mode == 2 && $time >= t_end) begin
      mode = 3;
      t_end = $time + ERASE_NS;
    end else if ((mode == 1 || mode == 3) && $time >= t_end) begin
      mode = 0;
    end
  end
endmodule : flash_model

// ==== test/tb.sv ====
// Self-checking bench for the flash erase controller.
// Assumes the controller header and a behavioural flash model.
`include "erase_ctl_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [28:0] UNL [5] = '{{21'h00_0555, 8'hAA},
    {21'h00_02AA, 8'h55}, {21'h00_0555, 8'h80}, {21'h00_0555, 8'hAA},
    {21'h00_02AA, 8'h55}};
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [20:0] fa, sa;
  logic [7:0] dq_in, dq_out;
  logic dq_oe, we_n, oe_n, cs_n, frst_n, rb;
  int bad_count, comparisons, seed;
  logic [28:0] wq[$];
  flash_erase_host #(.ADD_WINDOW(20), .SUSPEND_WAIT(10)) u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(fa),
    .data_bus_byte_in(dq_in), .data_bus_byte_out(dq_out),
    .data_bus_byte_oe(dq_oe), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_cs_n(cs_n), .flash_reset_n(frst_n), .ready_busy_output(rb));
  flash_model u_flash (.rst_n(frst_n), .we_n(we_n), .oe_n(oe_n),
    .cs_n(cs_n), .addr(fa), .din(dq_out), .dout(dq_in), .rb(rb));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  // Log every write cycle at its rising strobe; oe is still high there
  always @(posedge we_n) if (dq_oe === 1'b1) wq.push_back({fa, dq_out});
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task end_of_test();
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // One APB transfer; answer taken at the edge pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Start an operation and poll until the controller is idle
  task run(input logic [2:0] op);
    apb(1, `REG_CTRL, {29'h0, op} | 32'h8000_0000);
    do apb(0, `REG_STATUS, 0); while (rd[`ST_BUSY] !== 1'b0);
  endtask : run
  // Expected address and data of write n of a six-write erase
  function automatic logic [28:0] exp_cyc(input int n,
                                          input logic [28:0] last);
    return (n < 5) ? UNL[n] : last;
  endfunction : exp_cyc
  task seq_chk(input logic [28:0] last);
    check(wq.size(), 6);
    for (int i = 0; i < 6; i++) check(wq[i], exp_cyc(i, last));
    wq.delete();
  endtask : seq_chk
  task ready_wait();
    wait (rb === 1'b1);
    repeat (4) @(posedge pclk);
    apb(1, `REG_STATUS, 32'h0000_0012);
  endtask : ready_wait
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {clk_en, seed, bad_count, comparisons} = {1'b1, 32'd41884, 64'd0};
    repeat (6) @(posedge pclk);
    presetn <= 1;
    // Idle status and an unmapped address
    apb(0, `REG_STATUS, 0);
    check(rd, 32'h0000_0004);
    apb(0, 12'h0_FF0, 0);
    check(err, 1'b1);
    // Chip erase, then suspend and a new chip erase must send nothing
    run(1);
    seq_chk({21'h00_0555, 8'h10});
    run(4);
    run(1);
    check(wq.size(), 0);
    ready_wait();
    // Random sectors: add, suspend, status read, resume twice
    repeat (3) begin
      sa = $random(seed);
      apb(1, `REG_SADDR, {11'h0, sa});
      run(2);
      seq_chk({sa, 8'h30});
      sa = $random(seed);
      apb(1, `REG_SADDR, {11'h0, sa});
      run(3);
      check(rd[`ST_TIMER], 1'b1);
      check(wq.pop_front(), {sa, 8'h30});
      run(4);
      check(wq.pop_front(), {sa, 8'hB0});
      run(6);
      apb(0, `REG_POLL, 0);
      check(rd[7:0], 8'h80);
      apb(1, `REG_SADDR, {11'h0, ~sa});
      run(6);
      apb(0, `REG_POLL, 0);
      check(rd[7:0], 8'hFF);
      run(5);
      check(wq.pop_front(), {~sa, 8'h30});
      run(5);
      check(wq.size(), 0);
      ready_wait();
    end
    // Add with the window long closed is refused
    run(3);
    check(wq.size(), 0);
    // Hardware reset in mid sector erase
    run(2);
    wq.delete();
    presetn <= 0;
    @(posedge pclk);
    check(frst_n, 1'b0);
    #1 check(rb, 1'b1);
    end_of_test();
  end
endmodule : tb
